// ===== dv/dual_dac_serial_loader_tb.sv
`timescale 1ns/1ps
module dual_dac_serial_loader_tb;
  import dac_loader_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, serial_in, shut, ld_a, ld_b;
  logic [11:0] code_a, code_b;
  logic [12:0] mv_a, mv_b;
  logic [15:0] shift;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  serial_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in));
  dual_dac_serial_loader dut_u (.REF_CLK_I(ref_clk), .RST_I(rst), .SCLK_I(sclk),
    .CS_N_I(cs_n), .SERIAL_IN_I(serial_in), .CODE_A_O(code_a), .CODE_B_O(code_b),
    .MV_A_O(mv_a), .MV_B_O(mv_b), .SHUTDOWN_O(shut), .LOAD_A_O(ld_a),
    .LOAD_B_O(ld_b), .SHIFT_O(shift));
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [12:0] mv(input logic [11:0] c);
    return 13'(int'(c) * 4000 / 4096);
  endfunction : mv
  // Chip select stays low until after the load, so a load on its rise is caught.
  task automatic frame(input logic [15:0] w, input int n, input logic [1:0] ld);
    int k;
    k = 0;
    host_u.send(w, n);
    while ({ld_a, ld_b} === 2'b00 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check({ld_a, ld_b}, ld);
    @(posedge ref_clk);
    #1;
    host_u.end_frame();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : frame
  task automatic t_reset;
    check({code_a, code_b}, {CODE_RESET, CODE_RESET});
    check({mv_a, mv_b, shut}, {13'h07d0, 13'h07d0, 1'b0});
    check(shift, 16'h0000);
  endtask : t_reset
  task automatic t_load;
    frame(16'h4123, 18, 2'b10);
    check({code_a, code_b}, {12'h123, CODE_RESET});
    check(shift, 16'h4123);
    check(mv_a, mv(12'h123));
    frame(16'h8fff, 16, 2'b01);
    check({code_a, code_b}, {12'h123, 12'hfff});
    check(mv_b, mv(12'hfff));
  endtask : t_load
  task automatic t_ignore;
    host_u.idle(10);
    repeat (20) @(posedge ref_clk);
    check({ld_a, ld_b, shift}, {2'b00, 16'h8fff});
    frame(16'h8555, 9, 2'b00);
    check({code_b, shift}, {12'hfff, 16'h8fff});
  endtask : t_ignore
  task automatic t_shutdown;
    frame(16'h2456, 16, 2'b10);
    check({shut, mv_a, mv_b}, {1'b1, 13'h0000, 13'h0000});
    frame(16'h8321, 16, 2'b01);
    check({shut, code_b, mv_b}, {1'b1, 12'h321, 13'h0000});
    frame(16'h0789, 16, 2'b10);
    check({shut, mv_a, mv_b}, {1'b0, mv(12'h789), mv(12'h321)});
  endtask : t_shutdown
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_reset();
    t_load();
    t_ignore();
    t_shutdown();
    finish_test();
  end
endmodule : dual_dac_serial_loader_tb

// ===== dv/serial_host.sv
`timescale 1ns/1ps
module serial_host (
  output logic sclk_o, // Serial clock, also toggled by idle outside frames.
  output logic cs_n_o, // Chip select, active low.
  output logic sdi_o // Serial data, MSB first.
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Bits past the sixteenth carry inverted data, so a device that keeps shifting is caught.
  task automatic send(input logic [15:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_o = (i == 3) ? 1'b0 : (i < 16) ? w[15 - i] : ~w[i - 16];
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
  endtask : send
  task automatic end_frame;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask : end_frame
  task automatic idle(input int n);
    repeat (n) begin
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
      sdi_o = ~sdi_o;
    end
  endtask : idle
endmodule : serial_host

// ===== rtl/dac_loader_pkg.sv
package dac_loader_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CHAN_POS = 15;
  localparam int PD_POS = 13;
  localparam int ZERO_POS = 12;
  localparam logic [4:0] LAST_COUNT = 5'h0f;
  localparam logic [4:0] DONE_COUNT = 5'h10;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  // Midscale code gives the bipolar zero output level.
  localparam logic [11:0] CODE_RESET = 12'h800;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [12:0] CODE_SPAN = 13'h1000;
  localparam int ZERO_MV = 2000;
  localparam int FULL_MV = 4000;
  typedef logic [11:0] code_t;
endpackage : dac_loader_pkg

// ===== rtl/dual_dac_serial_loader.sv
`timescale 1ns/1ps
module dual_dac_serial_loader
  import dac_loader_pkg::*;
(
  input wire logic REF_CLK_I, // Core clock, 125 MHz.
  input wire logic RST_I, // Asynchronous power-on reset, active high.
  input wire logic SCLK_I, // Serial clock from host.
  input wire logic CS_N_I, // Chip select, active low.
  input wire logic SERIAL_IN_I, // Serial data, MSB first.
  output logic [11:0] CODE_A_O, // Channel A register.
  output logic [11:0] CODE_B_O, // Channel B register.
  output logic [12:0] MV_A_O, // Channel A output in millivolts.
  output logic [12:0] MV_B_O, // Channel B output in millivolts.
  output logic SHUTDOWN_O, // Both channels powered down.
  output logic LOAD_A_O, // One-cycle pulse on channel A load.
  output logic LOAD_B_O, // One-cycle pulse on channel B load.
  output logic [15:0] SHIFT_O // Last completed frame word.
);
  import dac_loader_pkg::*;

  // Millivolt level for a code, shared by both channels.
  function automatic logic [12:0] code_to_mv(input code_t code);
    logic [23:0] prod;
    prod = 24'(code) * 24'(FULL_MV);
    return 13'(prod / 24'(CODE_SPAN));
  endfunction : code_to_mv

  // Serial domain. Chip select acts as an async clear of the counter, so the
  // frame restarts only on a fresh falling edge.
  logic [15:0] input_shift_reg;
  logic [4:0] bit_count;
  logic frame_toggle;
  wire [15:0] next_shift = {input_shift_reg[14:0], SERIAL_IN_I};
  wire last_edge = (bit_count == LAST_COUNT);
  wire frame_open = (bit_count != DONE_COUNT);

  frame_if link ();

  always_ff @(posedge SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      input_shift_reg <= SHIFT_RESET;
      frame_toggle <= 1'b0;
    end else if (!CS_N_I && frame_open) begin
      input_shift_reg <= next_shift;
      if (last_edge) begin
        frame_toggle <= ~frame_toggle;
      end
    end
  end

  // Counter: cleared whenever chip select is high or at reset.
  wire cnt_clr = RST_I | CS_N_I;
  always_ff @(posedge SCLK_I or posedge cnt_clr) begin
    if (cnt_clr) begin
      bit_count <= 5'h00;
    end else if (frame_open) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  // Serial-side checks run on the link clock, which may stop between frames; a_idle_zero samples on the core clock.
  a_shift_in: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!CS_N_I && frame_open) |=> input_shift_reg == {$past(input_shift_reg[14:0]), $past(SERIAL_IN_I)})
    else $error("serial bit not shifted in");

  a_count_range: assert property (@(posedge SCLK_I) disable iff (RST_I)
    bit_count <= DONE_COUNT)
    else $error("bit counter past sixteen");

  a_toggle_hold: assert property (@(posedge SCLK_I) disable iff (RST_I)
    CS_N_I |=> $stable(frame_toggle))
    else $error("frame flag moved with chip select high");

  a_toggle_last: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!CS_N_I && last_edge) |=> frame_toggle != $past(frame_toggle))
    else $error("sixteenth edge did not flag a frame");

  a_toggle_mid: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!CS_N_I && !last_edge) |=> $stable(frame_toggle))
    else $error("frame flagged before sixteenth edge");

  a_toggle_done: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!CS_N_I && !frame_open) |=> $stable(frame_toggle))
    else $error("extra edge flagged a frame");

  a_idle_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CS_N_I |-> bit_count == 5'h00)
    else $error("bit counter not cleared by chip select");

  assign link.toggle = frame_toggle;
  assign link.word = input_shift_reg;

  logic frame_pulse;
  logic [15:0] frame_word;

  frame_sync u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .link(link),
    .pulse_o(frame_pulse),
    .word_o(frame_word)
  );

  // Core domain decoding; bits 14 and 12 are deliberately unused.
  wire chan_b = frame_word[CHAN_POS];
  wire pd_req = frame_word[PD_POS];
  wire [11:0] frame_code = frame_word[CODE_BITS-1:0];
  logic pd_chan;
  wire next_shutdown = pd_req ? 1'b1 : (SHUTDOWN_O && (chan_b != pd_chan));

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CODE_A_O <= CODE_RESET;
      CODE_B_O <= CODE_RESET;
      SHUTDOWN_O <= 1'b0;
      pd_chan <= 1'b0;
      LOAD_A_O <= 1'b0;
      LOAD_B_O <= 1'b0;
      SHIFT_O <= SHIFT_RESET;
    end else begin
      LOAD_A_O <= frame_pulse && !chan_b;
      LOAD_B_O <= frame_pulse && chan_b;
      if (frame_pulse) begin
        SHIFT_O <= frame_word;
        // Codes load even in shutdown and are held for later.
        if (chan_b) begin
          CODE_B_O <= frame_code;
        end else begin
          CODE_A_O <= frame_code;
        end
        SHUTDOWN_O <= next_shutdown;
        if (pd_req && !SHUTDOWN_O) begin
          pd_chan <= chan_b;
        end
      end
    end
  end

  // Outputs read zero in shutdown; the analog stage would float or ground.
  wire [12:0] level_a = SHUTDOWN_O ? 13'h0000 : code_to_mv(CODE_A_O);
  wire [12:0] level_b = SHUTDOWN_O ? 13'h0000 : code_to_mv(CODE_B_O);

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MV_A_O <= 13'(ZERO_MV);
      MV_B_O <= 13'(ZERO_MV);
    end else begin
      MV_A_O <= level_a;
      MV_B_O <= level_b;
    end
  end

  a_mid_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (!SHUTDOWN_O && CODE_A_O == CODE_MID) |=> (MV_A_O == 13'(ZERO_MV)))
    else $error("midscale code not at bipolar zero");
  a_both_off: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    SHUTDOWN_O |=> (MV_A_O == 13'h0000 && MV_B_O == 13'h0000))
    else $error("shutdown not applied to both outputs");
  a_pd_enter: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && pd_req) |=> SHUTDOWN_O)
    else $error("shutdown frame did not power down");
  a_wrong_release: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && !pd_req && SHUTDOWN_O && chan_b != pd_chan) |=> SHUTDOWN_O)
    else $error("shutdown released by other channel");
  a_right_release: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && !pd_req && chan_b == pd_chan) |=> !SHUTDOWN_O)
    else $error("shutdown not released");
  a_load_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && !chan_b) |=> (CODE_A_O == $past(frame_code) && LOAD_A_O))
    else $error("channel A not loaded");
  a_held_b: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && !chan_b) |=> $stable(CODE_B_O))
    else $error("channel B changed on A frame");
  a_shift_hold: assert property (@(posedge SCLK_I) disable iff (RST_I)
    CS_N_I |=> $stable(input_shift_reg))
    else $error("shift register moved with chip select high");
  a_count_stop: assert property (@(posedge SCLK_I) disable iff (RST_I)
    (!CS_N_I && !frame_open) |=> $stable(input_shift_reg))
    else $error("shift after sixteenth edge");

  // Core-side checks; the synchronised pulse is the only event that moves state.
  a_load_b: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && chan_b) |=> (CODE_B_O == $past(frame_code) && LOAD_B_O))
    else $error("channel B not loaded");

  a_held_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && chan_b) |=> $stable(CODE_A_O))
    else $error("channel A changed on B frame");

  a_no_load: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !frame_pulse |=> (!LOAD_A_O && !LOAD_B_O))
    else $error("load pulse without a frame");

  a_codes_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !frame_pulse |=> ($stable(CODE_A_O) && $stable(CODE_B_O)))
    else $error("code changed without a frame");

  a_shut_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !frame_pulse |=> $stable(SHUTDOWN_O))
    else $error("shutdown changed without a frame");

  a_one_load: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !(LOAD_A_O && LOAD_B_O))
    else $error("both channels loaded at once");

  a_shift_copy: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    frame_pulse |=> SHIFT_O == $past(frame_word))
    else $error("frame word not reported");

  a_shift_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !frame_pulse |=> $stable(SHIFT_O))
    else $error("frame word changed without a frame");

  a_mv_a_level: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !SHUTDOWN_O |=> MV_A_O == code_to_mv($past(CODE_A_O)))
    else $error("channel A level wrong");

  a_mv_b_level: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !SHUTDOWN_O |=> MV_B_O == code_to_mv($past(CODE_B_O)))
    else $error("channel B level wrong");

  a_mid_zero_b: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (!SHUTDOWN_O && CODE_B_O == CODE_MID) |=> (MV_B_O == 13'(ZERO_MV)))
    else $error("channel B midscale not at bipolar zero");

  a_mv_range: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    MV_A_O <= 13'(FULL_MV) && MV_B_O <= 13'(FULL_MV))
    else $error("output level above full scale");

  a_pd_keep: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && SHUTDOWN_O) |=> $stable(pd_chan))
    else $error("shutdown channel changed while shut");

  a_pd_set: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && pd_req && !SHUTDOWN_O) |=> pd_chan == $past(chan_b))
    else $error("shutdown channel not recorded");

  a_held_off: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (frame_pulse && SHUTDOWN_O && !chan_b) |=> CODE_A_O == $past(frame_code))
    else $error("code not held during shutdown");

  a_pulse_gap: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    frame_pulse |=> !frame_pulse)
    else $error("frame pulse longer than one cycle");

  a_load_a_one: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_A_O |=> !LOAD_A_O)
    else $error("channel A load pulse too long");

  a_load_b_one: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_B_O |=> !LOAD_B_O)
    else $error("channel B load pulse too long");

  a_word_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $changed(frame_word) |-> frame_pulse)
    else $error("frame word moved without a pulse");

  a_chan_a_pick: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_A_O |-> !SHIFT_O[CHAN_POS])
    else $error("channel A loaded by B frame");

  a_chan_b_pick: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_B_O |-> SHIFT_O[CHAN_POS])
    else $error("channel B loaded by A frame");

  a_code_a_bits: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_A_O |-> CODE_A_O == SHIFT_O[CODE_BITS-1:0])
    else $error("channel A code bits wrong");

  a_code_b_bits: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    LOAD_B_O |-> CODE_B_O == SHIFT_O[CODE_BITS-1:0])
    else $error("channel B code bits wrong");

  a_load_pd: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ((LOAD_A_O || LOAD_B_O) && SHIFT_O[PD_POS]) |-> SHUTDOWN_O)
    else $error("loaded shutdown frame left outputs on");

  a_shut_rise: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(SHUTDOWN_O) |-> $past(frame_pulse && pd_req))
    else $error("shutdown without a shutdown frame");

  a_shut_fall: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(SHUTDOWN_O) |-> $past(frame_pulse && !pd_req && chan_b == pd_chan))
    else $error("shutdown left without matching frame");
endmodule : dual_dac_serial_loader

// ===== rtl/frame_if.sv
`timescale 1ns/1ps
interface frame_if;
  logic toggle;
  logic [15:0] word;
  modport src (output toggle, output word);
  modport dst (input toggle, input word);
endinterface : frame_if

// ===== rtl/frame_sync.sv
`timescale 1ns/1ps
module frame_sync
  import dac_loader_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  frame_if.dst link, // Frame toggle and word from serial domain.
  output logic pulse_o, // One-cycle pulse per new frame.
  output logic [15:0] word_o // Frame word valid with the pulse.
);
  logic sync1;
  logic sync2;
  logic sync3;
  wire new_frame = sync2 ^ sync3;

  // The word settles on the same serial edge that flips the toggle, more than one core cycle before sync2 shows it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      pulse_o <= 1'b0;
      word_o <= SHIFT_RESET;
    end else begin
      sync1 <= link.toggle;
      sync2 <= sync1;
      sync3 <= sync2;
      pulse_o <= new_frame;
      if (new_frame) begin
        word_o <= link.word;
      end
    end
  end
endmodule : frame_sync
